// ==== servo_input_command_logic.sv ====
// input-terminal command logic of a servo drive, with AXI4-Lite registers
// assumes terminal inputs already synchronous to clk_sys and debounced
//
// What this block does
// R1: two speed-step inputs pick one of three preset speeds for speed control.
// R2: both speed-step inputs off stops the motion.
// R3: proportional-mode input makes the speed loop proportional only.
// R4: zero-speed clamp forces the internal speed command to zero.
// R5: the host drives home limit to mark the origin area during homing.
// R6: homing start begins a homing operation in position mode.
// R7: command pulses count only while pulse-train enable is on.
// R8: position-error clear zeroes the position error counter.
// R9: forward run drives the motor forward during multistage speed.
// R10: forward run is the second function of the pulse-train enable terminal.
// R11: gain switch selects alternate gains; second function of proportional terminal.
// R12: gear select picks the second gear ratio and drops surplus pulses.
// R13: multiturn clear acts only after a continuous 4 s hold.
// R14: external fault input puts the device into alarm.
// R15: after a fault, only alarm reset leaves the alarm.
// R16: host removes the cause and servo enable before alarm reset.
// R17: each probe edge, rising or falling, latches the motor position.
// R18: probes are second functions of loop-type and home-start terminals.
// R19: releasing multiturn clear early restarts the hold timer, clearing nothing.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module servo_input_command_logic
    import servo_input_pkg::*;
#(
    parameter int unsigned HoldCycles = MT_HOLD_CYCLES
) (
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // input terminals
    input  wire logic              speedStepBit0,
    input  wire logic              speedStepBit1,
    input  wire logic              proportionalModeSelect,
    input  wire logic              zeroSpeedClamp,
    input  wire logic              homeLimitInput,
    input  wire logic              homeSearchStart,
    input  wire logic              pulseTrainEnable,
    input  wire logic              positionErrorClear,
    input  wire logic              backwardRun,
    input  wire logic              alarmResetInput,
    input  wire logic              loopTypeSwitch,
    // position command pulses and feedback
    input  wire logic              cmdPulse,
    input  wire logic              cmdPulseDir,
    input  wire logic              fbPulse,
    input  wire logic              fbPulseDir,
    input  wire logic [31:0]       motorPosition,
    // drive commands
    output logic [31:0]            speedCmd,
    output logic                   motionStop,
    output logic                   runForward,
    output logic                   runBackward,
    output logic                   propOnly,
    output logic                   gainAlt,
    output logic                   gearAlt,
    output logic                   surplusClear,
    output logic                   multiturnClearPulse,
    output logic                   homingActive,
    output logic                   alarm,
    output logic                   irq
);
    logic [CTRL_W-1:0] ctrl_q;
    logic [31:0]       speed_q [3];
    logic [31:0]       posErr_q;
    logic [31:0]       capture_q [2];
    logic [IRQ_W-1:0]  irqStat_q;
    logic [IRQ_W-1:0]  irqEn_q;
    home_state_t       home_q;
    logic [6:0]        prev_q;
    logic [IRQ_W-1:0]  events;

    // terminal function routing
    logic spd0Fn, spd1Fn, gearFn, mtClrFn, propFn, gainFn, clampFn, faultFn;
    logic penFn, fwdFn, modeFn, homeFn, probeA, probeB, posMode;
    always_comb begin
        spd0Fn  = speedStepBit0 && !ctrl_q[CTRL_ALT_SPD0];
        gearFn  = speedStepBit0 && ctrl_q[CTRL_ALT_SPD0];
        spd1Fn  = speedStepBit1 && !ctrl_q[CTRL_ALT_SPD1];
        mtClrFn = speedStepBit1 && ctrl_q[CTRL_ALT_SPD1];
        propFn  = proportionalModeSelect && !ctrl_q[CTRL_ALT_PROP]; // R11
        gainFn  = proportionalModeSelect && ctrl_q[CTRL_ALT_PROP]; // R11
        clampFn = zeroSpeedClamp && !ctrl_q[CTRL_ALT_CLAMP];
        faultFn = zeroSpeedClamp && ctrl_q[CTRL_ALT_CLAMP];
        penFn   = pulseTrainEnable && !ctrl_q[CTRL_ALT_PEN]; // R10
        fwdFn   = pulseTrainEnable && ctrl_q[CTRL_ALT_PEN]; // R10
        modeFn  = loopTypeSwitch && !ctrl_q[CTRL_ALT_MODE];
        probeA  = loopTypeSwitch && ctrl_q[CTRL_ALT_MODE]; // R18
        homeFn  = homeSearchStart && !ctrl_q[CTRL_ALT_HOME];
        probeB  = homeSearchStart && ctrl_q[CTRL_ALT_HOME]; // R18
        // with the mode terminal reassigned the mode comes from software
        posMode = ctrl_q[CTRL_ALT_MODE] ? ctrl_q[CTRL_POS_MODE] : !modeFn;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prev_q <= 7'h00;
        end else begin
            prev_q <= {alarmResetInput, probeB, probeA, homeLimitInput, homeFn, gearFn, faultFn};
        end
    end

    logic faultRise, gearRise, homeRise, limitRise, rstRise;
    logic [1:0] probeEdge;
    assign faultRise    = faultFn && !prev_q[0];
    assign gearRise     = gearFn && !prev_q[1];
    assign homeRise     = homeFn && !prev_q[2];
    assign limitRise    = homeLimitInput && !prev_q[3];
    assign probeEdge[0] = probeA ^ prev_q[4]; // R17
    assign probeEdge[1] = probeB ^ prev_q[5]; // R17
    assign rstRise      = alarmResetInput && !prev_q[6];

    // speed step, stop, direction and loop mode
    logic [1:0] step;
    assign step = {spd1Fn, spd0Fn}; // R1
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            speedCmd    <= 32'h0000_0000;
            motionStop  <= 1'b1;
            runForward  <= 1'b0;
            runBackward <= 1'b0;
            propOnly    <= 1'b0;
            gainAlt     <= 1'b0;
        end else begin
            motionStop  <= (step == 2'h0) || alarm; // R2
            if (step == 2'h0 || clampFn || alarm) begin
                speedCmd <= 32'h0000_0000; // R4
            end else begin
                speedCmd <= speed_q[2'(step - 2'h1)]; // R1
            end
            // forward wins if the host asserts both directions
            runForward  <= !posMode && fwdFn && step != 2'h0 && !alarm; // R9
            runBackward <= !posMode && !fwdFn && backwardRun && ctrl_q[CTRL_ALT_PEN]
                           && step != 2'h0 && !alarm;
            propOnly    <= propFn; // R3
            gainAlt     <= gainFn; // R11
        end
    end

    // electronic gear select
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            gearAlt      <= 1'b0;
            surplusClear <= 1'b0;
        end else begin
            gearAlt      <= gearFn; // R12
            surplusClear <= gearRise; // R12
        end
    end

    // position error counter: commanded pulses minus feedback pulses
    logic [31:0] cmdDelta, fbDelta;
    assign cmdDelta = (penFn && posMode && cmdPulse) ? (cmdPulseDir ? 32'hFFFF_FFFF
                                                                    : 32'h0000_0001)
                                                     : 32'h0000_0000; // R7
    assign fbDelta  = fbPulse ? (fbPulseDir ? 32'hFFFF_FFFF : 32'h0000_0001) : 32'h0000_0000;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            posErr_q <= 32'h0000_0000;
        end else if (positionErrorClear) begin
            posErr_q <= 32'h0000_0000; // R8
        end else begin
            posErr_q <= posErr_q + cmdDelta - fbDelta;
        end
    end

    // homing: started by the start input, ended when the home limit is reached
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            home_q <= HOME_IDLE;
        end else begin
            unique case (home_q)
                HOME_IDLE: begin
                    if (homeRise && posMode && !alarm) begin
                        home_q <= HOME_SEEK; // R6
                    end
                end
                HOME_SEEK: begin
                    // leaving position mode or tripping aborts the search
                    if (limitRise || alarm || !posMode) begin
                        home_q <= HOME_IDLE; // R5
                    end
                end
            endcase
        end
    end
    assign homingActive = (home_q == HOME_SEEK);

    // alarm: set wins over reset, so a held fault keeps the drive tripped
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            alarm <= 1'b0;
        end else if (faultFn) begin
            alarm <= 1'b1; // R14
        end else if (rstRise) begin
            alarm <= 1'b0; // R15
        end
    end

    multiturn_hold_timer #(
        .HoldCycles (HoldCycles)
    ) uHold (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .holdIn     (mtClrFn),
        .clearPulse (multiturnClearPulse)
    );

    // probe captures
    for (genvar i = 0; i < 2; i++) begin : gCap
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                capture_q[i] <= 32'h0000_0000;
            end else if (probeEdge[i]) begin
                capture_q[i] <= motorPosition; // R17
            end
        end
    end

    // interrupt status
    assign events = {probeEdge[1], probeEdge[0], multiturnClearPulse,
                     home_q == HOME_SEEK && limitRise, faultRise};
    assign irq    = |(irqStat_q & irqEn_q);

    // AXI4-Lite write path
    logic              awHeld_q, wHeld_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic [DATA_W-1:0] wData_q;
    logic [3:0]        wStrb_q;
    logic              doWrite;
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
    assign doWrite       = awHeld_q && wHeld_q;

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = data[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic known(input logic [ADDR_W-1:0] a);
        return a[1:0] == 2'h0 && a <= OFS_IRQ_EN;
    endfunction

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
            awAddr_q     <= '0;
            wData_q      <= '0;
            wStrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_q  <= CTRL_RESET;
            speed_q <= '{default: 32'h0000_0000};
            irqEn_q <= '0;
        end else if (doWrite) begin
            unique case (awAddr_q)
                OFS_CTRL:   ctrl_q     <= CTRL_W'(mergeBytes({24'h0, ctrl_q}, wData_q,
                                                             wStrb_q));
                OFS_SPEED1: speed_q[0] <= mergeBytes(speed_q[0], wData_q, wStrb_q);
                OFS_SPEED2: speed_q[1] <= mergeBytes(speed_q[1], wData_q, wStrb_q);
                OFS_SPEED3: speed_q[2] <= mergeBytes(speed_q[2], wData_q, wStrb_q);
                OFS_IRQ_EN: irqEn_q    <= wStrb_q[0] ? wData_q[IRQ_W-1:0] : irqEn_q;
                default: begin
                end
            endcase
        end
    end

    // new events win over a clear written in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irqStat_q <= '0;
        end else if (doWrite && awAddr_q == OFS_IRQ_CLR && wStrb_q[0]) begin
            irqStat_q <= (irqStat_q & ~wData_q[IRQ_W-1:0]) | events;
        end else begin
            irqStat_q <= irqStat_q | events;
        end
    end

    // AXI4-Lite read path, answer one cycle after the address is taken
    logic [31:0] status;
    assign status = {23'h0, step, motionStop, posMode, gainAlt, propOnly,
                     gearAlt, homingActive, alarm};
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                OFS_CTRL:     s_axi_rdata <= {24'h0, ctrl_q};
                OFS_SPEED1:   s_axi_rdata <= speed_q[0];
                OFS_SPEED2:   s_axi_rdata <= speed_q[1];
                OFS_SPEED3:   s_axi_rdata <= speed_q[2];
                OFS_STATUS:   s_axi_rdata <= status;
                OFS_POSERR:   s_axi_rdata <= posErr_q;
                OFS_CAPA:     s_axi_rdata <= capture_q[0];
                OFS_CAPB:     s_axi_rdata <= capture_q[1];
                OFS_IRQ_STAT: s_axi_rdata <= {27'h0, irqStat_q};
                OFS_IRQ_EN:   s_axi_rdata <= {27'h0, irqEn_q};
                default:      s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_stop_both_off: assert property (@(posedge clk_sys) disable iff (!resetn) // R2
        !spd0Fn && !spd1Fn |=> motionStop && speedCmd == 32'h0000_0000)
        else $error("motion not stopped with both steps off");
    a_step_speed: assert property (@(posedge clk_sys) disable iff (!resetn) // R1
        spd0Fn && spd1Fn && !clampFn && !alarm |=> speedCmd == $past(speed_q[2]))
        else $error("third step speed not applied");
    a_zero_clamp: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
        clampFn |=> speedCmd == 32'h0000_0000)
        else $error("clamp did not zero speed command");
    a_prop_gain: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
        proportionalModeSelect |=> propOnly != gainAlt)
        else $error("proportional terminal not routed to one function");
    a_pulse_gate: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
        !penFn && !fbPulse && !positionErrorClear |=> $stable(posErr_q))
        else $error("pulse counted while disabled");
    a_err_clear: assert property (@(posedge clk_sys) disable iff (!resetn) // R8
        positionErrorClear |=> posErr_q == 32'h0000_0000)
        else $error("position error not cleared");
    a_gear_switch: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
        gearRise |=> gearAlt && surplusClear ##1 !surplusClear || gearRise)
        else $error("gear change without surplus clear pulse");
    a_fault_alarm: assert property (@(posedge clk_sys) disable iff (!resetn) // R14
        faultFn |=> alarm ##1 motionStop && !runForward && !runBackward)
        else $error("fault did not trip");
    a_alarm_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // R15
        alarm && !rstRise |=> alarm)
        else $error("alarm left without reset");
    a_probe_latch: assert property (@(posedge clk_sys) disable iff (!resetn) // R17
        probeEdge[0] |=> capture_q[0] == $past(motorPosition))
        else $error("probe edge did not capture position");
    a_homing_start: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
        home_q == HOME_IDLE && homeRise && posMode && !alarm |=> homingActive)
        else $error("homing not started");
endmodule
`default_nettype wire

// ==== servo_input_pkg.sv ====
// constants shared by the input-terminal command logic
// assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus
package servo_input_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned MT_HOLD_S       = 4;
    localparam int unsigned MT_HOLD_CYCLES  = MT_HOLD_S * CLK_HZ;

    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;

    // register byte offsets
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_SPEED1      = 8'h04;
    localparam logic [7:0]  OFS_SPEED2      = 8'h08;
    localparam logic [7:0]  OFS_SPEED3      = 8'h0C;
    localparam logic [7:0]  OFS_STATUS      = 8'h10;
    localparam logic [7:0]  OFS_POSERR      = 8'h14;
    localparam logic [7:0]  OFS_CAPA        = 8'h18;
    localparam logic [7:0]  OFS_CAPB        = 8'h1C;
    localparam logic [7:0]  OFS_IRQ_STAT    = 8'h20;
    localparam logic [7:0]  OFS_IRQ_CLR     = 8'h24;
    localparam logic [7:0]  OFS_IRQ_EN      = 8'h28;

    // control register: second-function selects per shared terminal, and the software loop mode in bit 7
    localparam int          CTRL_ALT_SPD0   = 0;
    localparam int          CTRL_ALT_SPD1   = 1;
    localparam int          CTRL_ALT_PROP   = 2;
    localparam int          CTRL_ALT_CLAMP  = 3;
    localparam int          CTRL_ALT_PEN    = 4;
    localparam int          CTRL_ALT_MODE   = 5;
    localparam int          CTRL_ALT_HOME   = 6;
    localparam int          CTRL_POS_MODE   = 7;
    localparam int          CTRL_W          = 8;
    localparam logic [7:0]  CTRL_RESET      = 8'h80;

    // status register fields
    localparam int          ST_ALARM        = 0;
    localparam int          ST_HOMING       = 1;
    localparam int          ST_GEAR_ALT     = 2;
    localparam int          ST_PROP_ONLY    = 3;
    localparam int          ST_GAIN_ALT     = 4;
    localparam int          ST_POS_MODE     = 5;
    localparam int          ST_STOP         = 6;
    localparam int          ST_STEP_LO      = 7;

    // interrupt bits
    localparam int          IRQ_FAULT       = 0;
    localparam int          IRQ_HOMED       = 1;
    localparam int          IRQ_MTCLR       = 2;
    localparam int          IRQ_CAPA        = 3;
    localparam int          IRQ_CAPB        = 4;
    localparam int          IRQ_W           = 5;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic {HOME_IDLE, HOME_SEEK} home_state_t;
endpackage

// ==== multiturn_hold_timer.sv ====
// hold timer for the multiturn clear terminal
// assumes the input is already synchronous to clk_sys
`timescale 1ns/100ps
`default_nettype none
module multiturn_hold_timer
    import servo_input_pkg::*;
#(
    parameter int unsigned HoldCycles = MT_HOLD_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic holdIn,
    output logic      clearPulse
);
    logic [31:0] count_q;
    logic        done_q;

    // fires once per hold; releasing early restarts the count and clears nothing
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_q <= 32'h0000_0000;
            done_q  <= 1'b0;
        end else if (!holdIn) begin
            count_q <= 32'h0000_0000; // R19
            done_q  <= 1'b0;
        end else if (!done_q) begin
            count_q <= count_q + 32'h0000_0001;
            done_q  <= (count_q + 32'h0000_0001 >= HoldCycles); // R13
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            clearPulse <= 1'b0;
        end else begin
            clearPulse <= holdIn && !done_q && (count_q + 32'h0000_0001 >= HoldCycles);
        end
    end

    a_hold_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
        !holdIn |=> (count_q == 32'h0000_0000) && !clearPulse) // R19
        else $error("hold count not restarted on release");
    a_hold_length: assert property (@(posedge clk_sys) disable iff (!resetn)
        clearPulse |-> count_q >= HoldCycles) // R13
        else $error("multiturn clear before hold time");
endmodule
`default_nettype wire

// ==== host_terminal_model.sv ====
// host and switch model that drives the terminal levels
// assumes one clock; home limit answers a running homing one cycle later
`timescale 1ns/100ps
`default_nettype none
module host_terminal_model (
    input  wire logic        clk_sys,
    input  wire logic [10:0] cmd,
    input  wire logic        homingActive,
    output var logic  [10:0] term
);
    always_ff @(posedge clk_sys) term <= {cmd[10:5], homingActive, cmd[3:0]};
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the input-terminal command logic
// assumes host_terminal_model on the terminals and a short multiturn hold
`timescale 1ns/100ps
`default_nettype none
module tb import servo_input_pkg::*;;
    logic clk_sys = 1'b0, resetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cmdPulse = 1'b0;
    logic cmdPulseDir = 1'b0, fbPulse = 1'b0, fbPulseDir = 1'b0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [10:0] cmd = 11'h000;
    logic [31:0] s_axi_wdata = 32'h0, motorPosition = 32'h0, q;
    logic [1:0]  rs;
    int          fails = 0, n_tests = 0, pulses = 0;
    wire logic [10:0] term;
    wire logic [31:0] s_axi_rdata, speedCmd;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire logic motionStop, runForward, runBackward, propOnly, gainAlt, gearAlt, alarm;
    wire logic surplusClear, multiturnClearPulse, homingActive;
    servo_input_command_logic #(.HoldCycles(20)) dut (.*, .speedStepBit0(term[0]),
        .speedStepBit1(term[1]), .proportionalModeSelect(term[2]), .zeroSpeedClamp(term[3]),
        .homeLimitInput(term[4]), .homeSearchStart(term[5]), .pulseTrainEnable(term[6]),
        .positionErrorClear(term[7]), .backwardRun(term[8]), .alarmResetInput(term[9]),
        .loopTypeSwitch(term[10]));
    host_terminal_model host (.clk_sys, .cmd, .homingActive, .term);
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) pulses <= pulses + int'(multiturnClearPulse);
    always @(posedge clk_sys) motorPosition <= motorPosition + 32'h1;
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) fails++;
        if (got !== exp) $display("[FAIL] %0t got %h want %h", $time, got, exp);
    endtask
    // ready is combinational, so it is sampled mid-cycle and acted on at the next edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic aw, w, ar, done = 1'b0;
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {{3{wr}}, {2{!wr}}};
        for (int k = 0; k < 50 && !done; k++) begin
            @(negedge clk_sys);
            {aw, w, ar} = {s_axi_awready, s_axi_wready, s_axi_arready};
            done = s_axi_bvalid | s_axi_rvalid;
            {q, rs} = {s_axi_rdata, wr ? s_axi_bresp : s_axi_rresp};
            @(posedge clk_sys);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (ar) s_axi_arvalid <= 1'b0;
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        fails += int'(!done);
        if (!done) conclude();
    endtask
    // outputs trail the terminals by the model's edge plus the design's edge
    task automatic drive(input logic [10:0] c, input int n);
        @(posedge clk_sys);
        cmd <= c;
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic t_speed();
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(q, 32'h80);
        bus(1'b0, 8'h40, 32'h0);
        chk(32'(rs), 32'(RESP_SLVERR));
        bus(1'b1, OFS_CTRL, 32'h90);
        for (int s = 1; s < 4; s++) bus(1'b1, 8'(4 * s), 32'(s * 256));
        for (int s = 0; s < 4; s++) begin
            drive(11'h440 | 11'(s), 3);
            chk(speedCmd, 32'(s * 256));
            chk(32'({motionStop, runForward}), 32'(s == 0 ? 2 : 1));
        end
        drive(11'h501, 3);
        chk(32'({runForward, runBackward}), 32'h1);
        $display("speed steps done");
    endtask
    task automatic t_alarm();
        bus(1'b1, OFS_CTRL, 32'h88);
        bus(1'b1, OFS_IRQ_EN, 32'h1);
        drive(11'h408, 3);
        chk(32'({alarm, irq}), 32'h3);
        drive(11'h400, 3);
        chk(32'(alarm), 32'h1);
        drive(11'h600, 3);
        drive(11'h400, 3);
        chk(32'(alarm), 32'h0);
        bus(1'b1, OFS_IRQ_CLR, 32'h1);
        drive(11'h400, 1);
        chk(32'(irq), 32'h0);
        $display("external fault done");
    endtask
    task automatic t_multi();
        bus(1'b1, OFS_CTRL, 32'h82);
        drive(11'h402, 10);
        drive(11'h400, 3);
        chk(32'(pulses), 32'h0);
        drive(11'h402, 30);
        drive(11'h400, 3);
        chk(32'(pulses), 32'h1);
        $display("multiturn hold done");
    endtask
    task automatic t_modes();
        logic [31:0] v;
        bus(1'b1, OFS_CTRL, 32'h85);
        drive(11'h405, 2);
        chk(32'({gearAlt, surplusClear, gainAlt, propOnly}), 32'hE);
        bus(1'b1, OFS_CTRL, 32'h80);
        drive(11'h40F, 3);
        chk(speedCmd, 32'h0);
        chk(32'({propOnly, gainAlt}), 32'h2);
        drive(11'h020, 2);
        chk(32'(homingActive), 32'h1);
        drive(11'h000, 3);
        chk(32'(homingActive), 32'h0);
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(q, 32'h6);
        for (int i = 0; i < 2; i++) begin
            drive(i ? 11'h000 : 11'h040, 2);
            @(posedge clk_sys) cmdPulse <= 1'b1;
            repeat (3) @(posedge clk_sys);
            cmdPulse <= 1'b0;
            bus(1'b0, OFS_POSERR, 32'h0);
            chk(q, 32'h3);
        end
        drive(11'h080, 2);
        bus(1'b0, OFS_POSERR, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, OFS_CTRL, 32'hA0);
        for (int i = 1; i >= 0; i--) begin
            drive(i ? 11'h400 : 11'h000, 2);
            v = motorPosition - 32'h1;
            bus(1'b0, OFS_CAPA, 32'h0);
            chk(q, v);
        end
        $display("modes done");
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        t_speed();
        t_alarm();
        t_multi();
        t_modes();
        conclude();
    end
endmodule
`default_nettype wire
